// [ddr_strobe_input_capture.sv]
// Right-edge input capture: SDR, generic DDR and DDR memory modes.
// Assumes pins and strobe come from outside clk's domain; the strobe
// is a slow sampled input (125 ns period), edges found on clk.
//
// Functional notes
// [R1] Right-edge cell supports all generic input modes plus DDR memory capture.
// [R2] DDR memory mode samples data on both shifted strobe edges, two streams.
// [R3] Both streams resynchronised into system clock before reaching the core.
// [R4] Polarity select picks which clock edge the synchronisation registers use; here all use posedge clk and it delays memory-mode handoff one cycle.
// [R5] External strobe logic supplies shifted strobe and polarity select.
// [R6] Rising and falling streams stay on separate fixed outputs toward core.
`timescale 1ns/100ps
module ddr_strobe_input_capture #(
    parameter int unsigned W     = ddr_capture_pkg::DATA_W,
    parameter int unsigned DEPTH = ddr_capture_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Pins and strobe-side controls
    input  wire logic [W-1:0]          pad_data,
    input  wire logic                  shifted_read_strobe,
    input  wire logic                  sync_clock_polarity_sel,
    input  wire ddr_capture_pkg::capture_mode_t mode,
    // Core side
    output logic                       core_valid,
    input  wire logic                  core_ready,
    output logic [W-1:0]               core_rise_data,
    output logic [W-1:0]               core_fall_data,
    output logic                       overflow
);
    // ==========================================================
    // Input synchronisers
    // ==========================================================
    logic [W-1:0] pad_m_q, pad_s_q;
    logic [2:0]   dqs_q;
    logic         pol_m_q, pol_s_q;
    logic         strobe_rise, strobe_fall;

    // Two flops before any logic sees a pin; dqs_q[2] is edge history
    always_ff @(posedge clk) begin
        if (rst) begin
            pad_m_q <= '0;
            pad_s_q <= '0;
            dqs_q   <= '0;
            pol_m_q <= 1'b0;
            pol_s_q <= 1'b0;
        end else begin
            pad_m_q <= pad_data;
            pad_s_q <= pad_m_q;
            dqs_q   <= {dqs_q[1:0], shifted_read_strobe};
            pol_m_q <= sync_clock_polarity_sel;
            pol_s_q <= pol_m_q;
        end
    end

    assign strobe_rise = dqs_q[1] && !dqs_q[2];
    assign strobe_fall = !dqs_q[1] && dqs_q[2];

    // ==========================================================
    // Strobe-edge capture
    // ==========================================================
    logic [W-1:0] rise_cap_q, fall_cap_q;
    logic         pair_ready_q;
    logic         is_ddr;

    assign is_ddr = (mode != ddr_capture_pkg::MODE_SDR);

    // Separate registers per strobe edge form two streams [R2]
    always_ff @(posedge clk) begin
        if (rst) begin
            rise_cap_q <= '0;
            fall_cap_q <= '0;
        end else begin
            if (strobe_rise) begin
                rise_cap_q <= pad_s_q; // [R2]
            end
            if (strobe_fall && is_ddr) begin
                fall_cap_q <= pad_s_q; // [R2]
            end
        end
    end

    // A pair is complete on falling edge in DDR modes, rising in SDR [R1]
    always_ff @(posedge clk) begin
        if (rst) begin
            pair_ready_q <= 1'b0;
        end else begin
            pair_ready_q <= is_ddr ? strobe_fall : strobe_rise; // [R1]
        end
    end

    // ==========================================================
    // Resynchronisation stage with selectable phase
    // ==========================================================
    // Polarity select delays the handoff by one cycle, the sampled
    // equivalent of using the opposite sync-clock edge. Memory mode only.
    logic         hold_q;
    ddr_capture_pkg::word_pair_t hold_word_q;
    logic         sync_valid_q;
    ddr_capture_pkg::word_pair_t sync_word_q;
    logic         use_late;

    assign use_late = (mode == ddr_capture_pkg::MODE_DDR_MEMORY)
                   && (pol_s_q != ddr_capture_pkg::POL_RISE);

    // Hold register for the late phase [R4]
    always_ff @(posedge clk) begin
        if (rst) begin
            hold_q      <= 1'b0;
            hold_word_q <= '0;
        end else begin
            hold_q      <= pair_ready_q && use_late; // [R4]
            hold_word_q <= {rise_cap_q, fall_cap_q};
        end
    end

    // System-domain register pair feeding the buffer [R3]
    always_ff @(posedge clk) begin
        if (rst) begin
            sync_valid_q <= 1'b0;
            sync_word_q  <= '0;
        end else begin
            if (hold_q) begin
                sync_valid_q <= 1'b1; // [R3]
                sync_word_q  <= hold_word_q;
            end else if (pair_ready_q && !use_late) begin
                sync_valid_q <= 1'b1; // [R3]
                sync_word_q  <= {rise_cap_q, fall_cap_q};
            end else begin
                sync_valid_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Buffer toward core
    // ==========================================================
    logic       fifo_in_ready, fifo_out_valid, take;
    logic [2*W-1:0] fifo_out;

    pair_fifo #(.WIDTH(2*W), .DEPTH(DEPTH)) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (sync_valid_q),
        .in_ready  (fifo_in_ready),
        .in_data   (sync_word_q),
        .out_valid (fifo_out_valid),
        .out_ready (take),
        .out_data  (fifo_out)
    );

    // Output stage keeps every output on a flop; strobe data cannot
    // be stalled, so a full buffer drops the pair and flags it.
    assign take = fifo_out_valid && (!core_valid || core_ready);

    // Fixed lanes: rise data and fall data never swap [R6]
    always_ff @(posedge clk) begin
        if (rst) begin
            core_valid     <= 1'b0;
            core_rise_data <= '0;
            core_fall_data <= '0;
        end else if (take) begin
            core_valid     <= 1'b1;
            core_rise_data <= fifo_out[2*W-1:W]; // [R6]
            core_fall_data <= fifo_out[W-1:0];   // [R6]
        end else if (core_ready) begin
            core_valid <= 1'b0;
        end
    end

    // Sticky loss flag
    always_ff @(posedge clk) begin
        if (rst) begin
            overflow <= 1'b0;
        end else if (sync_valid_q && !fifo_in_ready) begin
            overflow <= 1'b1;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    property p_rise_capture;
        @(posedge clk) disable iff (rst)
        strobe_rise |=> rise_cap_q == $past(pad_s_q);
    endproperty
    a_rise_capture: assert property (p_rise_capture) // [R2]
        else $error("rise capture mismatch");

    property p_fall_capture;
        @(posedge clk) disable iff (rst)
        (strobe_fall && is_ddr) |=> fall_cap_q == $past(pad_s_q);
    endproperty
    a_fall_capture: assert property (p_fall_capture) // [R2]
        else $error("fall capture mismatch");

    property p_sdr_no_fall;
        @(posedge clk) disable iff (rst)
        !is_ddr |=> $stable(fall_cap_q);
    endproperty
    a_sdr_no_fall: assert property (p_sdr_no_fall) // [R1]
        else $error("fall register moved in SDR mode");

    property p_early_phase;
        @(posedge clk) disable iff (rst)
        (pair_ready_q && !use_late) |=> sync_valid_q;
    endproperty
    a_early_phase: assert property (p_early_phase) // [R4]
        else $error("early phase handoff missing");

    property p_late_phase;
        @(posedge clk) disable iff (rst)
        (pair_ready_q && use_late) |=> !sync_valid_q ##1 sync_valid_q;
    endproperty
    a_late_phase: assert property (p_late_phase) // [R4]
        else $error("late phase handoff wrong");

    property p_sync_source;
        @(posedge clk) disable iff (rst)
        sync_valid_q |-> $past(pair_ready_q) || $past(hold_q);
    endproperty
    a_sync_source: assert property (p_sync_source) // [R3]
        else $error("sync valid without capture");

    property p_lane_fixed;
        @(posedge clk) disable iff (rst)
        take |=> core_rise_data == $past(fifo_out[2*W-1:W])
              && core_fall_data == $past(fifo_out[W-1:0]);
    endproperty
    a_lane_fixed: assert property (p_lane_fixed) // [R6]
        else $error("core lanes swapped");

    property p_core_hold;
        @(posedge clk) disable iff (rst)
        (core_valid && !core_ready) |=> core_valid && $stable(core_rise_data);
    endproperty
    a_core_hold: assert property (p_core_hold) // [R6]
        else $error("core data dropped under stall");
endmodule // ddr_strobe_input_capture

// [ddr_capture_pkg.sv]
// Shared types and constants for the DDR strobe input capture block.
// Assumes a single 100 MHz system clock domain on the core side.
package ddr_capture_pkg;
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned FIFO_DEPTH  = 8;
    localparam logic        POL_RISE    = 1'b0;

    // Capture modes of the right-edge input cell
    typedef enum logic [1:0] {
        MODE_SDR = 2'b00,
        MODE_DDR_GENERIC = 2'b01,
        MODE_DDR_MEMORY = 2'b10
    } capture_mode_t;

    // One resynchronised word pair
    typedef struct packed {
        logic [DATA_W-1:0] rise_data;
        logic [DATA_W-1:0] fall_data;
    } word_pair_t;
endpackage

// [pair_fifo.sv]
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes both sides on clk; rst synchronous active high.
`timescale 1ns/100ps
module pair_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // pair_fifo

// [ddr_mem_model.sv]
// Read side of an external DDR memory: data pins and shifted strobe.
// Assumes bursts are started just after a clk edge; pins have no pull.
`timescale 1ns/100ps
module ddr_mem_model (
    // Pins toward the capture block
    output logic [ddr_capture_pkg::DATA_W-1:0] pad_data,
    output logic                               shifted_read_strobe
);
    // =========================================================
    // Idle pins
    initial begin
        pad_data = '0;
        shifted_read_strobe = 1'b0;
    end

    // =========================================================
    // One burst: 125 ns strobe period, data centred on each edge
    // Strobe stands low between bursts; released pins show the
    // inverse of the last value so a stale sample cannot match
    task automatic burst(input logic [ddr_capture_pkg::DATA_W-1:0] r, f);
        pad_data = r;
        #31.25 shifted_read_strobe = 1'b1;
        #31.25 pad_data = f;
        #31.25 shifted_read_strobe = 1'b0;
        #31.25 pad_data = ~f;
        // Short gap so chained bursts never drive the pins twice in one step
        #1;
    endtask
endmodule // ddr_mem_model

// [tb_top.sv]
// Self-checking bench for the DDR strobe input capture block.
// Assumes the memory model drives pins; the bench drives the core side.
`timescale 1ns/100ps
module tb_top;
    localparam int W = ddr_capture_pkg::DATA_W;
    localparam time D = 1ns;
    logic                           clk = 1'b0;
    logic                           rst = 1'b1;
    logic                           pol = 1'b0;
    logic                           core_ready = 1'b0;
    ddr_capture_pkg::capture_mode_t mode = ddr_capture_pkg::MODE_DDR_MEMORY;
    logic [W-1:0]                   pad_data;
    logic                           strobe;
    logic                           core_valid;
    logic [W-1:0]                   core_rise_data;
    logic [W-1:0]                   core_fall_data;
    logic                           overflow;
    int                             n_mismatch = 0;
    int                             compares = 0;
    int                             cyc = 0;
    int                             lat0;
    int                             lat1;

    // =========================================================
    // Clock, timeout and instances
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            summarize();
        end
    end
    ddr_mem_model ddr_mem_model_i (.pad_data(pad_data), .shifted_read_strobe(strobe));
    ddr_strobe_input_capture ddr_strobe_input_capture_i (
        .clk(clk), .rst(rst), .pad_data(pad_data), .shifted_read_strobe(strobe),
        .sync_clock_polarity_sel(pol), .mode(mode), .core_valid(core_valid),
        .core_ready(core_ready), .core_rise_data(core_rise_data),
        .core_fall_data(core_fall_data), .overflow(overflow));

    // =========================================================
    // Shared tasks
    task automatic chk(input logic [2*W-1:0] got, exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("mismatches=%0d compares=%0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Wait bounded for a pair, compare under mask, then take it
    task automatic get_pair(input logic [W-1:0] r, f, input logic [2*W-1:0] m,
                            output int lat);
        lat = 0;
        while (core_valid !== 1'b1 && lat < 100) begin
            @(posedge clk);
            #D;
            lat++;
        end
        chk({core_rise_data, core_fall_data} & m, {r, f} & m);
        core_ready = 1'b1;
        @(posedge clk);
        #D;
        core_ready = 1'b0;
        // Let an edge pass so a following call never re-raises ready at once
        @(posedge clk);
        #D;
    endtask

    // =========================================================
    // Scenarios
    // Pairs in memory mode keep rise and fall apart, edge polarity 0
    task automatic t_pairs();
        ddr_mem_model_i.burst(8'h5a, 8'ha5);
        get_pair(8'h5a, 8'ha5, 16'hffff, lat0);
        ddr_mem_model_i.burst(8'h00, 8'hff);
        get_pair(8'h00, 8'hff, 16'hffff, lat1);
    endtask
    // Late handoff costs exactly one more cycle, data unchanged
    task automatic t_pol();
        pol = 1'b1;
        ddr_mem_model_i.burst(8'h81, 8'h7e);
        get_pair(8'h81, 8'h7e, 16'hffff, lat1);
        chk((2*W)'(lat1), (2*W)'(lat0 + 1));
        pol = 1'b0;
    endtask
    // Generic modes still work; SDR carries only the rising sample;
    // polarity select must not delay the DDR handoff outside memory mode
    task automatic t_modes();
        ddr_capture_pkg::capture_mode_t ml[3];
        logic [2*W-1:0] mk[3];
        ml = '{ddr_capture_pkg::MODE_SDR, ddr_capture_pkg::MODE_DDR_GENERIC,
               ddr_capture_pkg::capture_mode_t'(2'b11)};
        mk = '{16'hff00, 16'hffff, 16'hffff};
        pol = 1'b1;
        for (int i = 0; i < 3; i++) begin
            mode = ml[i];
            ddr_mem_model_i.burst(8'h30 + 8'(i), 8'hc0 + 8'(i));
            get_pair(8'h30 + 8'(i), 8'hc0 + 8'(i), mk[i], lat1);
            if (i > 0) begin
                chk((2*W)'(lat1), (2*W)'(lat0));
            end
            repeat (20) @(posedge clk);
            #D;
        end
        mode = ddr_capture_pkg::MODE_DDR_MEMORY;
        pol = 1'b0;
    endtask
    // Core stalls: output stage plus eight buffered pairs fit, tenth is
    // dropped, order kept
    task automatic t_full();
        for (int i = 0; i < 10; i++) begin
            ddr_mem_model_i.burst(8'h10 + 8'(i), 8'he0 + 8'(i));
            if (i == 8) begin
                repeat (12) @(posedge clk);
                #D;
                chk((2*W)'(overflow), 16'h0000);
            end
        end
        repeat (12) @(posedge clk);
        #D;
        chk((2*W)'(overflow), 16'h0001);
        for (int i = 0; i < 9; i++) begin
            get_pair(8'h10 + 8'(i), 8'he0 + 8'(i), 16'hffff, lat1);
        end
        repeat (4) @(posedge clk);
        #D;
        chk((2*W)'({core_valid, overflow}), 16'h0001);
    endtask
    // Mid-run reset clears the sticky loss flag; capture works again after
    task automatic t_reset();
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #D;
        rst = 1'b0;
        chk((2*W)'({core_valid, overflow}), 16'h0000);
        repeat (3) @(posedge clk);
        #D;
        t_pairs();
    endtask

    // =========================================================
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        #D;
        rst = 1'b0;
        chk((2*W)'({core_valid, overflow}), 16'h0000);
        repeat (3) @(posedge clk);
        #D;
        t_pairs();
        t_pol();
        t_modes();
        t_full();
        t_reset();
        summarize();
    end
endmodule // tb_top
